// ===== logic/bus_cycle_pkg.sv
/*
  Shared constants and types for the local bus cycle block.
  Assumes a single 100 MHz system clock domain.
*/
package bus_cycle_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam logic [1:0] STAT_INTACK = 2'h0;
  localparam logic [1:0] STAT_READ = 2'h1;
  localparam logic [1:0] STAT_WRITE = 2'h2;
  localparam logic [1:0] STAT_IDLE = 2'h3;
  localparam logic [7:0] IO_HIGH_ZERO = 8'h00;
  localparam logic PHASE_RESET = 1'b0;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    CYC_MEM_READ,
    CYC_MEM_WRITE,
    CYC_FETCH,
    CYC_IO_READ,
    CYC_IO_WRITE,
    CYC_INTACK,
    CYC_HALT
  } cycle_kind_t;

  // Bit 1 is the active-low upper enable, bit 0 is address bit zero.
  function automatic logic [1:0] lane_code(input logic upper, input logic lower);
    lane_code = {~upper, ~lower};
  endfunction
endpackage

// ===== logic/local_bus_unit.sv
/*
  Local bus interface: clock halving, byte lanes, cycle status, ready and hold.
  Assumes the core presents one request at a time and holds it until done.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Processor clock is the system clock divided by two.
// - Reset rising edge aligns the divide-by-two phase.
// - Sample data on reads and acknowledges, drive it on writes.
// - Data lines active high, floated during hold acknowledge.
// - Drive 24-bit address, float it during hold acknowledge.
// - Address bit zero low when the lower lane carries data.
// - Upper eight address bits low for every I/O transfer.
// - Upper enable and A0 encode word, upper, lower byte; both high reserved.
// - One or both status lines low marks the start of a cycle.
// - Acknowledge encodes 00 with both selects low; 11 means no status.
// - Halt when address bit one is set, otherwise shutdown.
// - Memory data read 01, memory data write 10, 11 none.
// - With fetch select high and memory/IO low: I/O read or write.
// - Cycle lasts until ready sampled low; ready ignored in hold.
// - Float drivers then raise grant; drop grant when request falls.
// - Memory/IO high for memory and halt, low for I/O and acknowledge.
module local_bus_unit
  import bus_cycle_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire cycle_kind_t req_kind_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_upper_i,
  input wire logic req_lower_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic phase_o,
  input wire logic ready_n_i,
  input wire logic hold_req_i,
  output logic bus_grant_ack_o,
  output logic [ADDR_W-1:0] address_lines_o,
  output logic address_lines_oe_n_o,
  output logic upper_lane_enable_n_o,
  output logic [1:0] cycle_status_n_o,
  output logic mem_io_select_o,
  output logic fetch_or_intack_select_o,
  output logic ctrl_oe_n_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_STATUS, ST_CMD, ST_FLOAT, ST_HOLD} bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic phase;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic grant;
    logic [ADDR_W-1:0] addr;
    logic addr_oe_n;
    logic upper_n;
    logic [1:0] stat_n;
    logic mio;
    logic cod;
    logic ctrl_oe_n;
    logic [DATA_W-1:0] dout;
    logic dout_oe_n;
    logic is_read;
  } unit_state_t;

  unit_state_t st_q;
  unit_state_t st_d;
  logic [1:0] sync_w;
  logic ready_s;
  logic hold_s;

  pin_sync #(.WIDTH(2)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .async_i({ready_n_i, hold_req_i}),
    .sync_o(sync_w)
  );
  assign ready_s = ~sync_w[1];
  assign hold_s = sync_w[0];

  function automatic logic [1:0] status_code(input cycle_kind_t k);
    case (k)
      CYC_INTACK, CYC_HALT: status_code = STAT_INTACK;
      CYC_MEM_READ, CYC_FETCH, CYC_IO_READ: status_code = STAT_READ;
      CYC_MEM_WRITE, CYC_IO_WRITE: status_code = STAT_WRITE;
      default: status_code = STAT_IDLE;
    endcase
  endfunction

  function automatic logic is_io(input cycle_kind_t k);
    is_io = (k == CYC_IO_READ) || (k == CYC_IO_WRITE) || (k == CYC_INTACK);
  endfunction

  always_comb begin
    logic [1:0] lanes;
    lanes = lane_code(req_upper_i, req_lower_i);
    st_d = st_q;
    // All bus timing advances on the processor-clock edge, every second system clock.
    st_d.phase = ~st_q.phase;
    st_d.done = 1'b0;
    if (st_q.phase) begin
      case (st_q.state)
        ST_IDLE: begin
          if (hold_s) begin
            st_d.addr_oe_n = 1'b1;
            st_d.ctrl_oe_n = 1'b1;
            st_d.dout_oe_n = 1'b1;
            st_d.state = ST_FLOAT;
          end else if (req_valid_i) begin
            st_d.addr = req_addr_i;
            st_d.addr[0] = lanes[0];
            st_d.upper_n = lanes[1];
            if (is_io(req_kind_i)) begin
              st_d.addr[ADDR_W-1:16] = IO_HIGH_ZERO;
            end
            st_d.mio = ~is_io(req_kind_i);
            st_d.cod = (req_kind_i == CYC_FETCH) || (req_kind_i == CYC_IO_READ)
                       || (req_kind_i == CYC_IO_WRITE);
            st_d.stat_n = status_code(req_kind_i);
            st_d.is_read = (status_code(req_kind_i) == STAT_READ)
                           || (req_kind_i == CYC_INTACK);
            st_d.dout = req_wdata_i;
            st_d.dout_oe_n = (status_code(req_kind_i) != STAT_WRITE);
            st_d.state = ST_STATUS;
          end
        end
        ST_STATUS: begin
          st_d.stat_n = STAT_IDLE;
          st_d.state = ST_CMD;
        end
        ST_CMD: begin
          if (ready_s) begin
            if (st_q.is_read) begin
              st_d.rdata = data_lines_i;
            end
            st_d.done = 1'b1;
            st_d.dout_oe_n = 1'b1;
            st_d.state = ST_IDLE;
          end
        end
        ST_FLOAT: begin
          st_d.grant = 1'b1;
          st_d.state = ST_HOLD;
        end
        ST_HOLD: begin
          if (!hold_s) begin
            st_d.grant = 1'b0;
            st_d.addr_oe_n = 1'b0;
            st_d.ctrl_oe_n = 1'b0;
            st_d.state = ST_IDLE;
          end
        end
        default: st_d.state = ST_IDLE;
      endcase
    end
  end

  // Reset clears phase, so the first system edge after release starts phase one.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: ST_IDLE, phase: PHASE_RESET, done: 1'b0, rdata: '0, grant: 1'b0,
                addr: '0, addr_oe_n: 1'b0, upper_n: 1'b1, stat_n: STAT_IDLE, mio: 1'b0,
                cod: 1'b0, ctrl_oe_n: 1'b0, dout: '0, dout_oe_n: 1'b1, is_read: 1'b0};
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign req_done_o = st_q.done;
  assign rdata_o = st_q.rdata;
  assign phase_o = st_q.phase;
  assign bus_grant_ack_o = st_q.grant;
  assign address_lines_o = st_q.addr;
  assign address_lines_oe_n_o = st_q.addr_oe_n;
  assign upper_lane_enable_n_o = st_q.upper_n;
  assign cycle_status_n_o = st_q.stat_n;
  assign mem_io_select_o = st_q.mio;
  assign fetch_or_intack_select_o = st_q.cod;
  assign ctrl_oe_n_o = st_q.ctrl_oe_n;
  assign data_lines_o = st_q.dout;
  assign data_lines_oe_n_o = st_q.dout_oe_n;

  a_grant_floats: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_q.grant |-> (st_q.addr_oe_n && st_q.ctrl_oe_n && st_q.dout_oe_n))
    else $error("grant while drivers active");
  a_io_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.state == ST_CMD && !st_q.mio) |-> st_q.addr[ADDR_W-1:16] == IO_HIGH_ZERO)
    else $error("io upper address not zero");
  a_lane_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.state == ST_CMD && st_q.mio && st_q.stat_n != STAT_INTACK)
    |-> !(st_q.upper_n && st_q.addr[0]))
    else $error("reserved lane code");
  a_status_one_state: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.state == ST_STATUS && ce_i && st_q.phase) |=> st_q.stat_n == STAT_IDLE)
    else $error("status not released");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.state == ST_CMD && $past(st_q.state) == ST_CMD) |-> $stable(st_q.addr))
    else $error("address changed mid cycle");
  a_phase_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> st_q.phase != $past(st_q.phase))
    else $error("phase did not toggle");
  a_write_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q.state == ST_CMD && !st_q.dout_oe_n) |-> !st_q.is_read)
    else $error("driving data on read");
  a_hold_no_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_q.grant |=> !st_q.done)
    else $error("cycle ended in hold");
  c_read_done: cover property (@(posedge clk_i) st_q.done && st_q.is_read);
  c_write_done: cover property (@(posedge clk_i) st_q.done && !st_q.is_read);
  c_hold: cover property (@(posedge clk_i) st_q.grant);
endmodule // local_bus_unit
`default_nettype wire

// ===== logic/pin_sync.sv
/*
  Two-stage synchroniser for inputs that arrive from outside the clock domain.
  Assumes the surrounding logic reads only the second stage.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import bus_cycle_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (en_i) begin
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule // pin_sync
`default_nettype wire

// ===== test/bus_partner.sv
/*
  Far-side model: bus controller with memory and I/O that ends cycles by ready.
  Assumes status and address are taken straight from the device pins.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] stat_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [3:0] wait_i,
  output logic ready_n_o,
  output logic [15:0] data_o
);
  logic busy_q;
  logic [3:0] cnt_q;
  // An idle bus toggles each cycle so a stale value never passes for read data.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      ready_n_o <= 1'b1;
      data_o <= 16'h0000;
    end else if (!busy_q) begin
      ready_n_o <= 1'b1;
      data_o <= ~data_o;
      if (stat_n_i != 2'h3) begin
        busy_q <= 1'b1;
        cnt_q <= wait_i + 4'h7;
        data_o <= addr_i[15:0] ^ 16'h5a5a;
      end
    end else begin
      cnt_q <= cnt_q - 4'h1;
      ready_n_o <= !(cnt_q <= 4'h6 && cnt_q >= 4'h3);
      if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule // bus_partner
`default_nettype wire

// ===== test/local_bus_unit_test.sv
/*
  Testbench for the local bus unit: clock phase, cycle kinds, lanes and hold.
  Assumes the far-side model answers every status cycle with ready.
*/
`timescale 1ns/10ps
`default_nettype none
module local_bus_unit_test;
  import bus_cycle_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  cycle_kind_t req_kind_i = CYC_MEM_READ;
  logic [ADDR_W-1:0] req_addr_i = 24'h00_0000;
  logic req_upper_i = 1'b1;
  logic req_lower_i = 1'b1;
  logic [DATA_W-1:0] req_wdata_i = 16'h0000;
  logic hold_req_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] wait_i = 4'h0;
  logic req_done_o, phase_o, ready_n_i, grant, a_oe_n, upper_n, mio, cod, c_oe_n, d_oe_n;
  logic [1:0] stat_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rdata_o, d_out, far_data;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  local_bus_unit DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
    .req_upper_i(req_upper_i), .req_lower_i(req_lower_i), .req_wdata_i(req_wdata_i),
    .req_done_o(req_done_o), .rdata_o(rdata_o), .phase_o(phase_o), .ready_n_i(ready_n_i),
    .hold_req_i(hold_req_i), .bus_grant_ack_o(grant), .address_lines_o(addr),
    .address_lines_oe_n_o(a_oe_n), .upper_lane_enable_n_o(upper_n), .cycle_status_n_o(stat_n),
    .mem_io_select_o(mio), .fetch_or_intack_select_o(cod), .ctrl_oe_n_o(c_oe_n),
    .data_lines_i(d_oe_n ? far_data : d_out), .data_lines_o(d_out), .data_lines_oe_n_o(d_oe_n));
  bus_partner far_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .stat_n_i(stat_n), .addr_i(addr),
    .wait_i(wait_i), .ready_n_o(ready_n_i), .data_o(far_data));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // Runs one request to completion; the request is dropped in the cycle that done pulses.
  task automatic do_cycle(input cycle_kind_t k, input logic [23:0] a, input logic up,
      input logic lo, input logic [1:0] st, input logic m, input logic c);
    int n;
    logic wr;
    n = 0;
    wr = (k == CYC_MEM_WRITE || k == CYC_IO_WRITE);
    req_kind_i = k;
    req_addr_i = a;
    req_upper_i = up;
    req_lower_i = lo;
    req_wdata_i = a[15:0] ^ 16'h0ff0;
    req_valid_i = 1'b1;
    while (stat_n === STAT_IDLE && n < 40) begin step(); n++; end
    check("status", stat_n, st);
    check("mio_cod", {mio, cod}, {m, c});
    check("lanes", {upper_n, addr[0]}, {~up, ~lo});
    check("drive", {c_oe_n, a_oe_n, d_oe_n}, {2'h0, ~wr});
    if (wr) check("wdata", d_out, req_wdata_i);
    n = 0;
    do begin
      check("address", addr, {(m ? a[23:16] : 8'h00), a[15:1], ~lo});
      step();
      n++;
    end while (req_done_o !== 1'b1 && n < 80);
    req_valid_i = 1'b0;
    check("done", req_done_o, 1'b1);
    if (!wr && k != CYC_HALT) check("rdata", rdata_o, {a[15:1], ~lo} ^ 16'h5a5a);
    repeat (6) step();
  endtask

  task automatic t_phase();
    logic p;
    p = phase_o;
    repeat (4) begin step(); check("phase", phase_o, {~p}); p = phase_o; end
  endtask

  // With the enable low every register holds, so the phase may not move.
  task automatic t_freeze();
    logic p;
    p = phase_o;
    ce_i = 1'b0;
    repeat (3) begin step(); check("frozen", phase_o, p); end
    ce_i = 1'b1;
    step();
    check("thawed", phase_o, {~p});
  endtask

  task automatic t_memory();
    do_cycle(CYC_MEM_READ, 24'hab_cd12, 1'b1, 1'b1, STAT_READ, 1'b1, 1'b0);
    wait_i = 4'h8;
    do_cycle(CYC_MEM_WRITE, 24'h12_3456, 1'b0, 1'b1, STAT_WRITE, 1'b1, 1'b0);
    wait_i = 4'h0;
    do_cycle(CYC_FETCH, 24'hff_fffe, 1'b1, 1'b0, STAT_READ, 1'b1, 1'b1);
  endtask

  task automatic t_io();
    do_cycle(CYC_IO_READ, 24'h5c_8a41, 1'b0, 1'b1, STAT_READ, 1'b0, 1'b1);
    do_cycle(CYC_IO_WRITE, 24'h3e_ffff, 1'b1, 1'b0, STAT_WRITE, 1'b0, 1'b1);
  endtask

  task automatic t_special();
    do_cycle(CYC_INTACK, 24'h00_0000, 1'b0, 1'b1, STAT_INTACK, 1'b0, 1'b0);
    do_cycle(CYC_HALT, 24'h00_0002, 1'b1, 1'b1, STAT_INTACK, 1'b1, 1'b0);
    do_cycle(CYC_HALT, 24'h00_0000, 1'b1, 1'b1, STAT_INTACK, 1'b1, 1'b0);
  endtask

  // A request made during hold must wait, then run once the bus is regained.
  task automatic t_hold();
    int n;
    n = 0;
    hold_req_i = 1'b1;
    while (grant !== 1'b1 && n < 20) begin step(); n++; end
    check("grant", grant, 1'b1);
    check("float", {a_oe_n, c_oe_n, d_oe_n}, 3'h7);
    req_addr_i = 24'h00_0ace;
    req_valid_i = 1'b1;
    repeat (10) begin step(); check("refused", req_done_o, 1'b0); end
    hold_req_i = 1'b0;
    n = 0;
    while (grant !== 1'b0 && n < 20) begin step(); n++; end
    check("regain", {grant, a_oe_n}, 2'h0);
    do_cycle(CYC_MEM_READ, 24'h00_0ace, 1'b1, 1'b1, STAT_READ, 1'b1, 1'b0);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    step();
    check("phase_align", phase_o, 1'b1);
    t_phase();
    t_freeze();
    t_memory();
    t_io();
    t_special();
    t_hold();
    give_verdict();
  end
endmodule // local_bus_unit_test
`default_nettype wire
